//--- cpu_core_model.sv
// Behavioural CPU core that acknowledges requests after a delay
module cpu_core_model (
    input  logic       clk_i,
    input  logic       rst_b_i,
    input  logic       irq_i,
    input  logic       en_i,
    input  logic [3:0] dly_i,
    output logic       ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // One-cycle acknowledge; gated so one request is never acked twice
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 4'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            cnt_q <= 4'h0;
            if (irq_i && en_i && !ack_o) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == dly_i) begin
                    ack_o <= 1'b1;
                    cnt_q <= 4'h0;
                end
            end
        end
    end
endmodule // cpu_core_model

//--- interrupt_priority_status.v
// Priority fields, request arbitration and control/status register
// Structure in brief:
// - ten APB words, all answered without wait states
// - fourteen sources, each a flag, an enable and a 3-bit priority
// - one combinational winner search, then a registered request
// - trap requests from outside overrule the CPU level mask
// - status word shows the waiting request, the level and a vector
// Limitation: vector numbers per source are local to this group
// Trade-off: request is registered, so it trails the flag by a cycle
// Hazard: acknowledge clears by registered vector, never by live winner
// Hazard: an event in the clearing cycle keeps its flag set
// Limitation: trap sources have no flag here; TRAP_REQ_I is the request, the level pin only qualifies it
//
// The APB slave port and the placing of the registers were chosen for this implementation.
module interrupt_priority_status (
    input  wire        CLK_I,
    input  wire        RST_B_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    input  wire [13:0] SRC_EVENT_I,
    input  wire        CPU_ACK_I,
    input  wire        TRAP_REQ_I,
    input  wire [3:0]  TRAP_LEVEL_I,
    output reg         CPU_IRQ_O,
    output reg  [3:0]  CPU_IRQ_LEVEL_O,
    output reg  [6:0]  CPU_IRQ_VECTOR_O
);

`include "prio_status_consts.vh"

    // Position of each source in the flag, enable and priority arrays
    localparam SRC_LOW_VOLTAGE = 0;
    localparam SRC_CHARGE_TIME = 1;
    localparam SRC_U3_TX       = 2;
    localparam SRC_U3_RX       = 3;
    localparam SRC_U3_ERR      = 4;
    localparam SRC_U4_ERR      = 5;
    localparam SRC_I2C3_MST    = 6;
    localparam SRC_I2C3_SLV    = 7;
    localparam SRC_SPI3_EVT    = 8;
    localparam SRC_SPI3_FLT    = 9;
    localparam SRC_U4_TX       = 10;
    localparam SRC_U4_RX       = 11;
    localparam SRC_CAP_NINE    = 12;
    localparam SRC_CMP_NINE    = 13;
    reg  [2:0]  prio_q [0:`NUM_SRC-1];
    reg  [13:0] flag_q;
    reg  [13:0] enable_q;
    reg  [3:0]  cpu_level_q;
    reg         vec_capture_sel_q;
    reg         request_unacked_q;
    reg  [3:0]  new_cpu_level_q;
    reg  [6:0]  pending_vector_id_q;
    reg  [6:0]  acked_vector_q;

    // Access phase strobes; the slave never stalls, so these are commit points
    wire        wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire        rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
    reg         addr_hit;
    // One loop index per process; a shared one would have several writers
    integer     i_rst;
    integer     i_arb;
    integer     i_clr;

    // Matches for the words kept outside the priority array
    wire        hit_ctrl_status = (PADDR_I == `ADDR_CTRL_STATUS);
    wire        hit_src_flags   = (PADDR_I == `ADDR_SRC_FLAGS);
    wire        hit_src_enables = (PADDR_I == `ADDR_SRC_ENABLES);
    wire        hit_cpu_level   = (PADDR_I == `ADDR_CPU_LEVEL);

    // Write strobes for those words
    wire        wr_ctrl_status  = wr_en & hit_ctrl_status;
    wire        wr_src_flags    = wr_en & hit_src_flags;
    wire        wr_src_enables  = wr_en & hit_src_enables;
    wire        wr_cpu_level    = wr_en & hit_cpu_level;

    // Priority fields under their own names
    wire [2:0]  low_voltage_prio      = prio_q[SRC_LOW_VOLTAGE];
    wire [2:0]  charge_time_prio      = prio_q[SRC_CHARGE_TIME];
    wire [2:0]  uart_three_tx_prio    = prio_q[SRC_U3_TX];
    wire [2:0]  uart_three_rx_prio    = prio_q[SRC_U3_RX];
    wire [2:0]  uart_three_err_prio   = prio_q[SRC_U3_ERR];
    wire [2:0]  uart_four_err_prio    = prio_q[SRC_U4_ERR];
    wire [2:0]  i2c_three_master_prio = prio_q[SRC_I2C3_MST];
    wire [2:0]  i2c_three_slave_prio  = prio_q[SRC_I2C3_SLV];
    wire [2:0]  spi_three_event_prio  = prio_q[SRC_SPI3_EVT];
    wire [2:0]  spi_three_fault_prio  = prio_q[SRC_SPI3_FLT];
    wire [2:0]  uart_four_tx_prio     = prio_q[SRC_U4_TX];
    wire [2:0]  uart_four_rx_prio     = prio_q[SRC_U4_RX];
    wire [2:0]  capture_nine_prio     = prio_q[SRC_CAP_NINE];
    wire [2:0]  compare_nine_prio     = prio_q[SRC_CMP_NINE];

    // Zero-wait slave; unmapped addresses flagged as an error
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

    // Place a 3-bit field in a 16-bit word
    function [15:0] place;
        input [2:0] f;
        input integer pos;
        begin
            place = {13'h0000, f} << pos;
        end
    endfunction

    // Pick one 3-bit priority field out of a 32-bit word
    function [2:0] pick;
        input [31:0] w;
        input integer pos;
        begin
            pick = w[pos +: 3];
        end
    endfunction

    // Vector number to status field value; the field counts from vector eight
    function [6:0] vec_field;
        input [6:0] v;
        begin
            vec_field = v - `VEC_OFFSET;
        end
    endfunction

    // Strictly-above compare on 4-bit levels, shared by user and trap paths
    function above;
        input [3:0] a;
        input [3:0] b;
        begin
            above = (a > b);
        end
    endfunction

    // Address decode
    always @* begin
        case (PADDR_I)
            `ADDR_LOW_VOLTAGE, `ADDR_CHARGE_TIME, `ADDR_UART_THREE,
            `ADDR_U4ERR_I2C3, `ADDR_SPI3_UART4, `ADDR_CHANNEL_NINE,
            `ADDR_CTRL_STATUS, `ADDR_SRC_FLAGS, `ADDR_SRC_ENABLES,
            `ADDR_CPU_LEVEL: addr_hit = 1'b1;
            default:         addr_hit = 1'b0;
        endcase
    end

    // Priority field writes; only the mapped bits are stored
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (i_rst = 0; i_rst < `NUM_SRC; i_rst = i_rst + 1) begin
                prio_q[i_rst] <= `PRIO_RESET;
            end
        end else if (wr_en) begin
            case (PADDR_I)
                `ADDR_LOW_VOLTAGE: prio_q[0] <= pick(PWDATA_I, `POS_LO0);
                `ADDR_CHARGE_TIME: prio_q[1] <= pick(PWDATA_I, `POS_LO4);
                `ADDR_UART_THREE: begin
                    prio_q[2] <= pick(PWDATA_I, `POS_HI);
                    prio_q[3] <= pick(PWDATA_I, `POS_MID);
                    prio_q[4] <= pick(PWDATA_I, `POS_LO4);
                end
                `ADDR_U4ERR_I2C3: begin
                    prio_q[5] <= pick(PWDATA_I, `POS_HI);
                    prio_q[6] <= pick(PWDATA_I, `POS_LO4);
                    prio_q[7] <= pick(PWDATA_I, `POS_LO0);
                end
                `ADDR_SPI3_UART4: begin
                    prio_q[8]  <= pick(PWDATA_I, `POS_HI);
                    prio_q[9]  <= pick(PWDATA_I, `POS_MID);
                    prio_q[10] <= pick(PWDATA_I, `POS_LO4);
                    prio_q[11] <= pick(PWDATA_I, `POS_LO0);
                end
                `ADDR_CHANNEL_NINE: begin
                    prio_q[12] <= pick(PWDATA_I, `POS_LO4);
                    prio_q[13] <= pick(PWDATA_I, `POS_LO0);
                end
                default: ;
            endcase
        end
    end

    // capture select holds what software last wrote to bit 13; the only writable status bit
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            vec_capture_sel_q <= 1'b0;
        end else if (wr_ctrl_status) begin
            vec_capture_sel_q <= PWDATA_I[`BIT_VEC_CAPTURE];
        end
    end

    // Source enables; all off after reset so nothing fires unasked
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            enable_q <= 14'h0000;
        end else if (wr_src_enables) begin
            enable_q <= PWDATA_I[13:0];
        end
    end

    // CPU level as the core reports it; zero lets every enabled source with a nonzero priority pass
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cpu_level_q <= 4'h0;
        end else if (wr_cpu_level) begin
            cpu_level_q <= PWDATA_I[3:0];
        end
    end

    // Arbitration: highest priority enabled flagged source, lowest index wins ties
    // Sources that may compete: flagged and enabled
    wire [13:0] live_src = flag_q & enable_q;
    reg  [2:0]  best_prio;
    reg  [3:0]  best_idx;
    always @* begin
        best_prio = `PRIO_OFF;
        best_idx  = 4'h0;
        // Strict compare keeps the lowest index among equal priorities
        for (i_arb = 0; i_arb < `NUM_SRC; i_arb = i_arb + 1) begin
            if (live_src[i_arb] && prio_q[i_arb] != `PRIO_OFF &&
                prio_q[i_arb] > best_prio) begin
                best_prio = prio_q[i_arb];
                best_idx  = i_arb[3:0];
            end
        end
    end

    wire        pend_any   = (best_prio != `PRIO_OFF);
    wire [6:0]  best_vec   = `SRC_VEC_BASE + {3'b000, best_idx};
    // binary priority compare; strictly above CPU level
    wire        user_go    = pend_any && above({1'b0, best_prio}, cpu_level_q);
    // traps bypass the CPU level mask
    wire        trap_go    = TRAP_REQ_I && above(TRAP_LEVEL_I, `USER_LEVEL_MAX);
    wire        fire       = trap_go | user_go;
    wire [3:0]  fire_level = trap_go ? TRAP_LEVEL_I : {1'b0, best_prio};

    // Acknowledge of the request now on the outputs
    wire        ack_take   = CPU_ACK_I & CPU_IRQ_O;
    // A trap level on the outputs means no user source was served
    wire        ack_user   = ack_take & ~CPU_IRQ_LEVEL_O[3];
    // Served source from the registered vector, not the live winner,
    // so a source that overtakes in the acknowledge cycle keeps its flag
    wire [6:0]  served_idx = CPU_IRQ_VECTOR_O - `SRC_VEC_BASE;
    reg  [13:0] clr_mask;

    // Clear requests: the served source on acknowledge, or a zero from software
    always @* begin
        clr_mask = 14'h0000;
        for (i_clr = 0; i_clr < `NUM_SRC; i_clr = i_clr + 1) begin
            if (ack_user && served_idx == i_clr) begin
                clr_mask[i_clr] = 1'b1;
            end
            if (wr_src_flags && !PWDATA_I[i_clr]) begin
                clr_mask[i_clr] = 1'b1;
            end
        end
    end

    // Source flags: event sets, a clear request drops it; set wins a tie
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            flag_q <= 14'h0000;
        end else begin
            flag_q <= SRC_EVENT_I | (flag_q & ~clr_mask);
        end
    end

    // Request to the CPU and status register fields
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            CPU_IRQ_O           <= 1'b0;
            CPU_IRQ_LEVEL_O     <= 4'h0;
            CPU_IRQ_VECTOR_O    <= 7'h00;
            request_unacked_q   <= 1'b0;
            new_cpu_level_q     <= 4'h0;
            pending_vector_id_q <= 7'h00;
            acked_vector_q      <= 7'h00;
        end else begin
            // Low for one cycle after an acknowledge so the core sees a new edge
            CPU_IRQ_O        <= fire & ~ack_take;
            CPU_IRQ_LEVEL_O  <= fire_level;
            CPU_IRQ_VECTOR_O <= best_vec;
            // pending but held off by CPU level
            request_unacked_q <= pend_any & ~user_go;
            if (ack_take) begin
                new_cpu_level_q <= CPU_IRQ_LEVEL_O;
                acked_vector_q  <= vec_field(CPU_IRQ_VECTOR_O);
            end
            if (vec_capture_sel_q) begin
                pending_vector_id_q <= pend_any ? vec_field(best_vec) : 7'h00;
            end else if (ack_take) begin
                pending_vector_id_q <= vec_field(CPU_IRQ_VECTOR_O);
            end else begin
                pending_vector_id_q <= acked_vector_q;
            end
        end
    end

    // Register images; positions outside the fields are tied to zero here,
    // which keeps unimplemented bits at zero whatever software wrote
    // low voltage image
    wire [15:0] word_low_voltage = place(low_voltage_prio, `POS_LO0);
    wire [15:0] word_charge_time = place(charge_time_prio, `POS_LO4);
    wire [15:0] word_uart_three  = place(uart_three_tx_prio, `POS_HI) |
                                   place(uart_three_rx_prio, `POS_MID) |
                                   place(uart_three_err_prio, `POS_LO4);
    // UART four error and I2C three image
    wire [15:0] word_u4err_i2c3  = place(uart_four_err_prio, `POS_HI) |
                                   place(i2c_three_master_prio, `POS_LO4) |
                                   place(i2c_three_slave_prio, `POS_LO0);
    // SPI three and UART four image
    wire [15:0] word_spi3_uart4  = place(spi_three_event_prio, `POS_HI) |
                                   place(spi_three_fault_prio, `POS_MID) |
                                   place(uart_four_tx_prio, `POS_LO4) |
                                   place(uart_four_rx_prio, `POS_LO0);
    wire [15:0] word_chan_nine   = place(capture_nine_prio, `POS_LO4) |
                                   place(compare_nine_prio, `POS_LO0);
    // status image; gaps at 14, 12 and 7 read zero
    wire [15:0] word_ctrl_status = {request_unacked_q, 1'b0, vec_capture_sel_q, 1'b0,
                                    new_cpu_level_q, 1'b0, pending_vector_id_q};

    // Read mux; zero outside a read access phase and for unmapped addresses
    always @* begin
        PRDATA_O = `ZERO32;
        if (rd_en) begin
            case (PADDR_I)
                `ADDR_LOW_VOLTAGE:  PRDATA_O[15:0] = word_low_voltage;
                `ADDR_CHARGE_TIME:  PRDATA_O[15:0] = word_charge_time;
                `ADDR_UART_THREE:   PRDATA_O[15:0] = word_uart_three;
                `ADDR_U4ERR_I2C3:   PRDATA_O[15:0] = word_u4err_i2c3;
                `ADDR_SPI3_UART4:   PRDATA_O[15:0] = word_spi3_uart4;
                `ADDR_CHANNEL_NINE: PRDATA_O[15:0] = word_chan_nine;
                `ADDR_CTRL_STATUS:  PRDATA_O[15:0] = word_ctrl_status;
                `ADDR_SRC_FLAGS:    PRDATA_O[13:0] = flag_q;
                `ADDR_SRC_ENABLES:  PRDATA_O[13:0] = enable_q;
                `ADDR_CPU_LEVEL:    PRDATA_O[3:0]  = cpu_level_q;
                default:            PRDATA_O = `ZERO32;
            endcase
        end
    end

endmodule // interrupt_priority_status

//--- prio_status_checker.sv
// Port-level assertions for the interrupt priority and status block
module prio_status_checker (
    input logic        CLK_I,
    input logic        RST_B_I,
    input logic        PSEL_I,
    input logic        PENABLE_I,
    input logic        PWRITE_I,
    input logic [11:0] PADDR_I,
    input logic [31:0] PRDATA_O,
    input logic        PSLVERR_O,
    input logic        CPU_ACK_I,
    input logic        TRAP_REQ_I,
    input logic [3:0]  TRAP_LEVEL_I,
    input logic        CPU_IRQ_O,
    input logic [3:0]  CPU_IRQ_LEVEL_O,
    input logic [6:0]  CPU_IRQ_VECTOR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Read access phase and unimplemented bits per register
    wire rd = PSEL_I & PENABLE_I & ~PWRITE_I;
    function automatic logic rz(input logic [11:0] a, input logic [31:0] m);
        return rd && PADDR_I == a && (PRDATA_O & m) != 32'h0000_0000;
    endfunction
    property p_rd_idle; !rd |-> PRDATA_O == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_unmapped;
        PSEL_I && PENABLE_I && PADDR_I > 12'h024 |-> PSLVERR_O && (PWRITE_I || !PRDATA_O);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    property p_lvd; !rz(12'h000, 32'hFFFF_FFF8); endproperty
    a_lvd: assert property (p_lvd) else $error("low voltage bits");
    property p_ct; !rz(12'h004, 32'hFFFF_FF8F); endproperty
    a_ct: assert property (p_ct) else $error("charge time bits");
    property p_u3; !rz(12'h008, 32'hFFFF_888F); endproperty
    a_u3: assert property (p_u3) else $error("uart three bits");
    property p_ch9; !rz(12'h014, 32'hFFFF_FF88); endproperty
    a_ch9: assert property (p_ch9) else $error("channel nine bits");
    property p_stat; !rz(12'h018, 32'hFFFF_5080); endproperty
    a_stat: assert property (p_stat) else $error("status bits");
    // User requests carry a nonzero level and a vector of this group
    property p_vec;
        CPU_IRQ_O && !CPU_IRQ_LEVEL_O[3] |-> CPU_IRQ_LEVEL_O != 4'h0 &&
            CPU_IRQ_VECTOR_O >= 7'h50 && CPU_IRQ_VECTOR_O <= 7'h5D;
    endproperty
    a_vec: assert property (p_vec) else $error("user request level or vector");
    property p_trap; TRAP_REQ_I && TRAP_LEVEL_I[3] && !CPU_ACK_I |-> ##[1:2] CPU_IRQ_O; endproperty
    a_trap: assert property (p_trap) else $error("trap not raised");
    c_trap: cover property (CPU_IRQ_O && CPU_IRQ_LEVEL_O[3]);
    c_ack: cover property (CPU_IRQ_O && CPU_ACK_I);
    c_wait: cover property (rd && PADDR_I == 12'h018 && PRDATA_O[15]);
endmodule // prio_status_checker

//--- prio_status_consts.vh
// Constants for the interrupt priority and status block
`ifndef PRIO_STATUS_CONSTS_VH
`define PRIO_STATUS_CONSTS_VH

// Register byte addresses on the APB
`define ADDR_LOW_VOLTAGE     12'h000
`define ADDR_CHARGE_TIME     12'h004
`define ADDR_UART_THREE      12'h008
`define ADDR_U4ERR_I2C3      12'h00C
`define ADDR_SPI3_UART4      12'h010
`define ADDR_CHANNEL_NINE    12'h014
`define ADDR_CTRL_STATUS     12'h018
`define ADDR_SRC_FLAGS       12'h01C
`define ADDR_SRC_ENABLES     12'h020
`define ADDR_CPU_LEVEL       12'h024

// Priority field reset value and the disabled code
`define PRIO_RESET           3'b100
`define PRIO_OFF             3'b000

// Field positions (low bit of each 3-bit field)
`define POS_HI               12
`define POS_MID              8
`define POS_LO4              4
`define POS_LO0              0

// Status register fields
`define BIT_REQ_UNACKED      15
`define BIT_VEC_CAPTURE      13
`define POS_LEVEL            8
`define VEC_OFFSET           7'h08

// Number of sources in this group and first vector of the group
`define NUM_SRC              14
`define SRC_VEC_BASE         7'h50

`define ZERO32               32'h0000_0000
`define USER_LEVEL_MAX       4'h7
`endif

//--- tb_top.sv
// Register and request testbench for the interrupt priority block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, CPU_ACK_I, TRAP_REQ_I;
    logic        PREADY_O, PSLVERR_O, CPU_IRQ_O, ack_en, err;
    logic [11:0] PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O, rd;
    logic [13:0] SRC_EVENT_I;
    logic [3:0]  TRAP_LEVEL_I, CPU_IRQ_LEVEL_O, ack_dly;
    logic [6:0]  CPU_IRQ_VECTOR_O;
    int          num_errors = 0;
    int          checks = 0;
    logic [11:0] adr [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
    logic [31:0] rst_v [7] = '{32'h0000_0004, 32'h0000_0040, 32'h0000_4440, 32'h0000_4044,
                               32'h0000_4444, 32'h0000_0044, 32'h0000_0000};
    logic [31:0] msk [7] = '{32'h0000_0007, 32'h0000_0070, 32'h0000_7770, 32'h0000_7077,
                             32'h0000_7777, 32'h0000_0077, 32'h0000_2000};
    interrupt_priority_status u_dut (
        .CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
        .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
        .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SRC_EVENT_I(SRC_EVENT_I),
        .CPU_ACK_I(CPU_ACK_I), .TRAP_REQ_I(TRAP_REQ_I), .TRAP_LEVEL_I(TRAP_LEVEL_I),
        .CPU_IRQ_O(CPU_IRQ_O), .CPU_IRQ_LEVEL_O(CPU_IRQ_LEVEL_O),
        .CPU_IRQ_VECTOR_O(CPU_IRQ_VECTOR_O));
    cpu_core_model u_cpu (.clk_i(CLK_I), .rst_b_i(RST_B_I), .irq_i(CPU_IRQ_O),
                          .en_i(ack_en), .dly_i(ack_dly), .ack_o(CPU_ACK_I));
    // 250 MHz system clock
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Setup then access; data sampled at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (PREADY_O !== 1'b1 && n < 20);
        rd = PRDATA_O;
        err = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        if (PREADY_O !== 1'b1) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic wirq(input logic e);
        int n;
        n = 0;
        while (CPU_IRQ_O !== e && n < 20) begin
            @(posedge CLK_I);
            n++;
        end
        chk(32'(CPU_IRQ_O), 32'(e));
    endtask
    task automatic ev(input logic [13:0] m);
        @(posedge CLK_I);
        SRC_EVENT_I <= m;
        @(posedge CLK_I);
        SRC_EVENT_I <= 14'h0000;
        repeat (3) @(posedge CLK_I);
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge CLK_I);
        num_errors++;
        finish_test();
    end
    initial begin
        {RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, TRAP_REQ_I, ack_en} = 6'h00;
        {PADDR_I, PWDATA_I, SRC_EVENT_I, TRAP_LEVEL_I} = '0;
        ack_dly = 4'h3;
        repeat (10) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        for (int i = 0; i < 7; i++) rdc(adr[i], rst_v[i]);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, adr[i], 32'hFFFF_FFFF);
            rdc(adr[i], msk[i]);
        end
        rdc(12'h040, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        $display("test mask done");
        apb(1'b1, 12'h020, 32'h0000_3FFF);
        apb(1'b1, 12'h000, 32'h0000_0000);
        ev(14'h0001);
        chk(32'(CPU_IRQ_O), 32'h0000_0000);
        apb(1'b1, 12'h01C, 32'h0000_0000);
        $display("test disable done");
        apb(1'b1, 12'h024, 32'h0000_0005);
        apb(1'b1, 12'h008, 32'h0000_3500);
        ev(14'h000C);
        chk(32'(CPU_IRQ_O), 32'h0000_0000);
        rdc(12'h018, 32'h0000_A04B);
        apb(1'b1, 12'h024, 32'h0000_0004);
        wirq(1'b1);
        chk({CPU_IRQ_LEVEL_O, CPU_IRQ_VECTOR_O}, 32'h0000_02D3);
        ack_en <= 1'b1;
        wirq(1'b0);
        ack_en <= 1'b0;
        rdc(12'h018, 32'h0000_A54A);
        apb(1'b1, 12'h018, 32'h0000_0000);
        rdc(12'h018, 32'h0000_854B);
        $display("test arbitrate done");
        apb(1'b1, 12'h024, 32'h0000_0007);
        TRAP_LEVEL_I <= 4'h5;
        TRAP_REQ_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        chk(32'(CPU_IRQ_O), 32'h0000_0000);
        TRAP_LEVEL_I <= 4'h9;
        wirq(1'b1);
        chk(32'(CPU_IRQ_LEVEL_O), 32'h0000_0009);
        TRAP_REQ_I <= 1'b0;
        wirq(1'b0);
        $display("test trap done");
        finish_test();
    end
endmodule // tb_top
bind interrupt_priority_status prio_status_checker u_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
    .CPU_ACK_I(CPU_ACK_I), .TRAP_REQ_I(TRAP_REQ_I), .TRAP_LEVEL_I(TRAP_LEVEL_I),
    .CPU_IRQ_O(CPU_IRQ_O), .CPU_IRQ_LEVEL_O(CPU_IRQ_LEVEL_O),
    .CPU_IRQ_VECTOR_O(CPU_IRQ_VECTOR_O));
